// [include/mdr_cfg.svh]
// timing, layout and refresh constants for the muxed-address dram controller
// Overview of operation
// - Twelve address bits go out as five row bits, then seven column bits.
// - Row bits are stable before the row strobe rises and held afterwards.
// - Row strobe stays high while column bits are driven for the access.
// - The write strobe stays high through every read.
// - Latch hold control drops no earlier than latch setup after column valid.
// - Latch hold control drops before the address changes and the strobe falls.
// - Write strobe falls after address setup; address held after it rises.
// - Write pulse meets minimum width; data meets setup and hold at its rise.
// - A strobe pulse meeting active and recovery times refreshes the row.
// - Every row is refreshed within the refresh period.
`ifndef MDR_CFG_SVH
`define MDR_CFG_SVH

`define MDR_CLK_NS 4
`define MDR_ROW_BITS 5
`define MDR_COL_BITS 7
`define MDR_ROWS 32
`define MDR_SYNC_CYC 4

`define MDR_ROW_SETUP_NS 0
`define MDR_ROW_HOLD_NS 45
`define MDR_STROBE_ACTIVE_NS 140
`define MDR_STROBE_RECOVERY_NS 140
`define MDR_COL_ACCESS_NS 75
`define MDR_LATCH_SETUP_NS 75
`define MDR_WR_ADDR_SETUP_NS 35
`define MDR_WR_ADDR_HOLD_NS 5
`define MDR_WR_PULSE_NS 25
`define MDR_WR_DATA_SETUP_NS 45
`define MDR_WR_DATA_HOLD_NS 30
`define MDR_WR_STROBE_HOLD_NS 40
`define MDR_REFRESH_MS 2

`define MDR_CEIL_CYC(ns) (((ns) + `MDR_CLK_NS - 1) / `MDR_CLK_NS)
`define MDR_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define MDR_MIN1(c) (((c) < 1) ? 1 : (c))

`define MDR_ROW_SETUP_CYC `MDR_MIN1(`MDR_CEIL_CYC(`MDR_ROW_SETUP_NS))
`define MDR_ROW_HOLD_CYC `MDR_CEIL_CYC(`MDR_ROW_HOLD_NS)
`define MDR_ACTIVE_CYC `MDR_CEIL_CYC(`MDR_STROBE_ACTIVE_NS)
`define MDR_RECOVERY_CYC `MDR_CEIL_CYC(`MDR_STROBE_RECOVERY_NS)
`define MDR_LATCH_CYC `MDR_MAX(`MDR_CEIL_CYC(`MDR_COL_ACCESS_NS), `MDR_CEIL_CYC(`MDR_LATCH_SETUP_NS))
`define MDR_WR_SETUP_CYC `MDR_CEIL_CYC(`MDR_WR_ADDR_SETUP_NS)
`define MDR_WR_PULSE_CYC `MDR_MAX(`MDR_CEIL_CYC(`MDR_WR_PULSE_NS), `MDR_CEIL_CYC(`MDR_WR_DATA_SETUP_NS))
`define MDR_WR_HOLD_CYC `MDR_MAX(`MDR_CEIL_CYC(`MDR_WR_ADDR_HOLD_NS), \
  `MDR_MAX(`MDR_CEIL_CYC(`MDR_WR_DATA_HOLD_NS), `MDR_CEIL_CYC(`MDR_WR_STROBE_HOLD_NS)))
`define MDR_REFRESH_CYC ((`MDR_REFRESH_MS * 1000000) / `MDR_CLK_NS)
`define MDR_REFRESH_GUARD 256

`endif

// [include/mdr_pkg.sv]
// types shared by the dram controller modules
package mdr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ROW_SETUP, ST_ROW_HOLD, ST_COL_READ, ST_READ_SAMPLE,
    ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_ACTIVE_END, ST_RECOVER
  } mdr_state_e;

  typedef struct packed {
    logic row_strobe;
    logic output_hold_ctl;
    logic select_a_n;
    logic select_b_n;
    logic write_n;
    logic [4:0] shared_addr_lines;
    logic [1:0] column_only_lines;
    logic data_in;
  } mdr_pins_s;

  typedef struct packed {
    logic write;
    logic [11:0] addr;
    logic wdata;
  } mdr_req_s;

  typedef struct packed {
    mdr_state_e state;
    logic [7:0] cnt;
    logic [7:0] act;
    mdr_pins_s pins;
    mdr_req_s cur;
    logic refresh;
    logic ref_pend;
    logic [4:0] ref_row;
    logic [2:0] sync;
    logic rd_filt;
    logic rsp_valid;
    logic rsp_data;
  } mdr_regs_s;

endpackage

// [rtl/mdr_refresh_timer.sv]
// periodic per-row refresh request pulse
`timescale 1ns/1ns
module mdr_refresh_timer #(
  parameter int INTERVAL = 15000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // one-cycle request
  output logic tick
);
  localparam int W = $clog2(INTERVAL + 1);
  localparam logic [W-1:0] LAST = W'(INTERVAL - 1);

  logic [W-1:0] cnt_q;
  logic tick_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + W'(1);
    end
  end

  assign tick = tick_q;
endmodule

// [rtl/mdr_ctrl.sv]
// host-side controller driving a 4k x 1 muxed-address dynamic memory
`timescale 1ns/1ns
`include "mdr_cfg.svh"
module mdr_ctrl #(
  parameter int REFRESH_CYC = `MDR_REFRESH_CYC,
  parameter int ROWS = `MDR_ROWS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [11:0] req_addr,
  input wire logic req_wdata,
  // user response
  output logic rsp_valid,
  output logic rsp_data,
  // memory pins
  output logic row_strobe,
  output logic output_hold_ctl,
  output logic select_a_n,
  output logic select_b_n,
  output logic write_n,
  output logic [4:0] shared_addr_lines,
  output logic [1:0] column_only_lines,
  output logic data_in,
  input wire logic data_out
);
  localparam int ROW_INTERVAL = REFRESH_CYC / ROWS - `MDR_REFRESH_GUARD;
  localparam logic [7:0] C_SETUP = 8'(`MDR_ROW_SETUP_CYC);
  localparam logic [7:0] C_HOLD = 8'(`MDR_ROW_HOLD_CYC);
  localparam logic [7:0] C_ACTIVE = 8'(`MDR_ACTIVE_CYC);
  localparam logic [7:0] C_RECOV = 8'(`MDR_RECOVERY_CYC);
  localparam logic [7:0] C_LATCH = 8'(`MDR_LATCH_CYC);
  localparam logic [7:0] C_SYNC = 8'(`MDR_SYNC_CYC);
  localparam logic [7:0] C_WSETUP = 8'(`MDR_WR_SETUP_CYC);
  localparam logic [7:0] C_WPULSE = 8'(`MDR_WR_PULSE_CYC);
  localparam logic [7:0] C_WHOLD = 8'(`MDR_WR_HOLD_CYC);

  mdr_pkg::mdr_regs_s q, d;
  logic tick;

  function automatic logic [4:0] row_of(input logic [11:0] a);
    row_of = a[11:7];
  endfunction

  function automatic logic [6:0] col_of(input logic [11:0] a);
    col_of = a[6:0];
  endfunction

  function automatic logic done(input logic [7:0] cnt, input logic [7:0] n);
    done = (cnt >= n - 8'd1);
  endfunction

  mdr_refresh_timer #(
    .INTERVAL(ROW_INTERVAL)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.cnt = q.cnt + 8'd1;
    d.act = (q.act == 8'hff) ? q.act : q.act + 8'd1;
    d.rsp_valid = 1'b0;
    d.sync = {q.sync[1:0], data_out};
    // a change counts once second and third stage agree
    if (q.sync[1] == q.sync[2]) begin
      d.rd_filt = q.sync[2];
    end
    d.ref_pend = q.ref_pend | tick;
    case (q.state)
      mdr_pkg::ST_IDLE: begin
        d.cnt = 8'd0;
        if (q.ref_pend) begin
          d.refresh = 1'b1;
          d.pins.shared_addr_lines = q.ref_row;
          d.state = mdr_pkg::ST_ROW_SETUP;
        end else if (req_valid) begin
          d.refresh = 1'b0;
          d.cur = {req_write, req_addr, req_wdata};
          d.pins.shared_addr_lines = row_of(req_addr);
          d.state = mdr_pkg::ST_ROW_SETUP;
        end
      end
      mdr_pkg::ST_ROW_SETUP: begin
        if (done(q.cnt, C_SETUP)) begin
          d.pins.row_strobe = 1'b1;
          d.act = 8'd0;
          d.cnt = 8'd0;
          d.state = mdr_pkg::ST_ROW_HOLD;
        end
      end
      mdr_pkg::ST_ROW_HOLD: begin
        if (done(q.cnt, C_HOLD)) begin
          d.cnt = 8'd0;
          if (q.refresh) begin
            d.state = mdr_pkg::ST_ACTIVE_END;
          end else begin
            {d.pins.column_only_lines, d.pins.shared_addr_lines} = col_of(q.cur.addr);
            d.pins.select_a_n = 1'b0;
            d.pins.select_b_n = 1'b0;
            d.pins.data_in = q.cur.wdata;
            d.state = q.cur.write ? mdr_pkg::ST_WR_SETUP : mdr_pkg::ST_COL_READ;
          end
        end
      end
      mdr_pkg::ST_COL_READ: begin
        if (done(q.cnt, C_LATCH)) begin
          d.pins.output_hold_ctl = 1'b0;
          d.cnt = 8'd0;
          d.state = mdr_pkg::ST_READ_SAMPLE;
        end
      end
      mdr_pkg::ST_READ_SAMPLE: begin
        if (done(q.cnt, C_SYNC)) begin
          d.rsp_valid = 1'b1;
          d.rsp_data = q.rd_filt;
          d.pins.select_a_n = 1'b1;
          d.pins.select_b_n = 1'b1;
          d.state = mdr_pkg::ST_ACTIVE_END;
        end
      end
      mdr_pkg::ST_WR_SETUP: begin
        if (done(q.cnt, C_WSETUP)) begin
          d.pins.write_n = 1'b0;
          d.cnt = 8'd0;
          d.state = mdr_pkg::ST_WR_PULSE;
        end
      end
      mdr_pkg::ST_WR_PULSE: begin
        if (done(q.cnt, C_WPULSE)) begin
          d.pins.write_n = 1'b1;
          d.cnt = 8'd0;
          d.state = mdr_pkg::ST_WR_HOLD;
        end
      end
      mdr_pkg::ST_WR_HOLD: begin
        if (done(q.cnt, C_WHOLD)) begin
          d.rsp_valid = 1'b1;
          d.rsp_data = q.cur.wdata;
          d.pins.select_a_n = 1'b1;
          d.pins.select_b_n = 1'b1;
          d.state = mdr_pkg::ST_ACTIVE_END;
        end
      end
      mdr_pkg::ST_ACTIVE_END: begin
        if (q.act >= C_ACTIVE - 8'd1) begin
          d.pins.row_strobe = 1'b0;
          d.cnt = 8'd0;
          d.state = mdr_pkg::ST_RECOVER;
          if (q.refresh) begin
            d.ref_row = q.ref_row + 5'd1;
            d.ref_pend = tick; // set wins over clear
          end
        end
      end
      mdr_pkg::ST_RECOVER: begin
        if (done(q.cnt, C_RECOV)) begin
          d.pins.output_hold_ctl = 1'b1;
          d.state = mdr_pkg::ST_IDLE;
        end
      end
      default: begin
        d.state = mdr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{state: mdr_pkg::ST_IDLE, cnt: 8'h00, act: 8'h00,
             pins: '{row_strobe: 1'b0, output_hold_ctl: 1'b1, select_a_n: 1'b1, select_b_n: 1'b1,
                     write_n: 1'b1, shared_addr_lines: 5'h00, column_only_lines: 2'h0, data_in: 1'b0},
             cur: '0, refresh: 1'b0, ref_pend: 1'b0, ref_row: 5'h00, sync: 3'h0, rd_filt: 1'b0,
             rsp_valid: 1'b0, rsp_data: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign req_ready = (q.state == mdr_pkg::ST_IDLE) && !q.ref_pend;
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;
  assign row_strobe = q.pins.row_strobe;
  assign output_hold_ctl = q.pins.output_hold_ctl;
  assign select_a_n = q.pins.select_a_n;
  assign select_b_n = q.pins.select_b_n;
  assign write_n = q.pins.write_n;
  assign shared_addr_lines = q.pins.shared_addr_lines;
  assign column_only_lines = q.pins.column_only_lines;
  assign data_in = q.pins.data_in;

  ////////////////////////////////////////////////////////////////////////////
  // assertions and their helper counters

  logic [7:0] hi_cnt, lo_cnt, col_age;
  logic col_phase;
  assign col_phase = q.state inside {mdr_pkg::ST_COL_READ, mdr_pkg::ST_READ_SAMPLE,
                                     mdr_pkg::ST_WR_SETUP, mdr_pkg::ST_WR_PULSE, mdr_pkg::ST_WR_HOLD};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'hff; // long idle before the first strobe
      col_age <= 8'h00;
    end else begin
      hi_cnt <= !row_strobe ? 8'h00 : (hi_cnt == 8'hff ? hi_cnt : hi_cnt + 8'd1);
      lo_cnt <= row_strobe ? 8'h00 : (lo_cnt == 8'hff ? lo_cnt : lo_cnt + 8'd1);
      col_age <= !col_phase ? 8'h00 : (col_age == 8'hff ? col_age : col_age + 8'd1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence addr_steady8;
    $stable(shared_addr_lines) [*8];
  endsequence

  row_hold_a: assert property ($rose(row_strobe) |-> addr_steady8 ##1 $stable(shared_addr_lines) [*4])
    else $error("row address changed during row hold");
  strobe_col_a: assert property (col_phase |-> row_strobe)
    else $error("row strobe low during column access");
  read_we_a: assert property ((col_phase && !q.cur.write) |-> write_n)
    else $error("write strobe low in a read");
  latch_setup_a: assert property ($fell(output_hold_ctl) |-> col_age >= C_LATCH)
    else $error("hold control dropped too early");
  latch_before_fall_a: assert property (($fell(row_strobe) && !q.refresh) |->
                                        (!output_hold_ctl || q.cur.write))
    else $error("hold control still high at strobe fall in a read");
  wr_setup_a: assert property ($fell(write_n) |-> col_age >= C_WSETUP && !select_a_n && !select_b_n)
    else $error("write strobe before address setup");
  wr_pulse_a: assert property ($fell(write_n) |-> !write_n [*8] ##1 !write_n [*4])
    else $error("write pulse too short");
  wr_hold_a: assert property ($rose(write_n) |-> ($stable(data_in) && $stable(shared_addr_lines)) [*8])
    else $error("data or address changed in write hold");
  strobe_active_a: assert property ($fell(row_strobe) |-> $past(hi_cnt) >= C_ACTIVE - 8'd1)
    else $error("strobe active time too short");
  strobe_recov_a: assert property ($rose(row_strobe) |-> $past(lo_cnt) >= C_RECOV - 8'd1)
    else $error("strobe recovery time too short");
  refresh_row_a: assert property ((q.state == mdr_pkg::ST_ROW_HOLD && q.refresh) |->
                                  shared_addr_lines == q.ref_row)
    else $error("refresh cycle on wrong row");
endmodule

// [dv/mdr_mem_model.sv]
// behavioural model of the 4k x 1 muxed-address dynamic memory
`timescale 1ns/1ns
module mdr_mem_model #(
  parameter real RFSH_NS = 2000000.0
) (
  // memory pins
  input wire logic row_strobe,
  input wire logic output_hold_ctl,
  input wire logic select_a_n,
  input wire logic select_b_n,
  input wire logic write_n,
  input wire logic [4:0] shared_addr_lines,
  input wire logic [1:0] column_only_lines,
  input wire logic data_in,
  // data pin
  output logic data_out
);
  logic mem [0:4095];
  realtime last_ref [0:31];
  realtime rise_t, fall_t, col_t, wf_t, wr_t, din_t;
  logic [4:0] row_q;
  logic held_q, float_q, v, lastv, up;
  int viol;
  wire [11:0] a = {row_q, column_only_lines, shared_addr_lines};
  wire [11:0] a_late;
  wire sel = !select_a_n && !select_b_n;
  wire sel_late;
  ////////////////////////////////////////////////////////////
  // data stays wrong until access delays run out
  assign #75 a_late = a;
  assign #35 sel_late = sel;
  initial begin
    viol = 0;
    up = 0;
    held_q = 0;
    float_q = 1;
    lastv = 0;
    fall_t = -1e3;
    wr_t = -1e3;
    col_t = 0;
    wf_t = 0;
    din_t = 0;
    foreach (mem[i]) mem[i] = 0;
    foreach (last_ref[i]) last_ref[i] = 0;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge row_strobe) begin
    row_q = shared_addr_lines;
    float_q = 0;
    if ($realtime - fall_t < 140) viol++;
    // stale row loses its charge
    if ($realtime - last_ref[row_q] > RFSH_NS) begin
      viol++;
      for (int c = 0; c < 128; c++) mem[{row_q, c[6:0]}] = ~mem[{row_q, c[6:0]}];
    end
    rise_t = $realtime;
    up = 1;
  end
  always @(negedge row_strobe) if (up) begin
    if ($realtime - rise_t >= 140) last_ref[row_q] = $realtime;
    else viol++;
    fall_t = $realtime;
    up = 0;
  end
  always @(shared_addr_lines or column_only_lines) begin
    if (up && $realtime - rise_t < 45) viol++;
    if ($realtime - wr_t < 5) viol++;
    col_t = $realtime;
  end
  ////////////////////////////////////////////////////////////
  always @(negedge write_n) if (sel) begin
    wf_t = $realtime;
    if ($realtime - col_t < 35) viol++;
  end
  always @(posedge write_n) if (sel) begin
    if ($realtime - wf_t < 25 || $realtime - din_t < 45) viol++;
    mem[a] = data_in;
    wr_t = $realtime;
  end
  always @(data_in) begin
    if ($realtime - wr_t < 30) viol++;
    din_t = $realtime;
  end
  always @(negedge output_hold_ctl) begin
    // taken from the cell directly, v may already show the old hold
    held_q = !write_n ? 1'b1 : (a_late === a ? mem[a] : ~mem[a]);
    if ($realtime - col_t < 75) viol++;
  end
  always @(posedge output_hold_ctl) if (!row_strobe) float_q = 1;
  ////////////////////////////////////////////////////////////
  // released pin shows the inverse of its last value
  always @* begin
    if (output_hold_ctl) v = !write_n ? 1'b1 : (a_late === a ? mem[a] : ~mem[a]);
    else v = held_q;
    if (sel && sel_late && !float_q) begin
      data_out = v;
      lastv = v;
    end else data_out = ~lastv;
  end
endmodule

// [dv/mdr_ctrl_tb.sv]
// self-checking bench for the dram controller against the memory model
`timescale 1ns/1ns
module mdr_ctrl_tb;
  localparam int RD_LAT = 37;
  localparam int WR_LAT = 45;
  logic clk, reset, req_valid, req_write, req_wdata, data_out, req_ready, rsp_valid, rsp_data;
  logic row_strobe, output_hold_ctl, select_a_n, select_b_n, write_n, data_in;
  logic [11:0] req_addr;
  logic [4:0] shared_addr_lines;
  logic [1:0] column_only_lines;
  logic [31:0] rows_seen;
  int fail_count, n_tests;
  logic [11:0] tab_a [6] = '{12'h000, 12'hfff, 12'hf80, 12'h07f, 12'h555, 12'haaa};
  mdr_ctrl #(.REFRESH_CYC(16384), .ROWS(32)) dut_u (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .row_strobe(row_strobe),
    .output_hold_ctl(output_hold_ctl), .select_a_n(select_a_n), .select_b_n(select_b_n),
    .write_n(write_n), .shared_addr_lines(shared_addr_lines), .column_only_lines(column_only_lines),
    .data_in(data_in), .data_out(data_out));
  mdr_mem_model #(.RFSH_NS(65536.0)) mem_u (.row_strobe(row_strobe), .output_hold_ctl(output_hold_ctl),
    .select_a_n(select_a_n), .select_b_n(select_b_n), .write_n(write_n),
    .shared_addr_lines(shared_addr_lines), .column_only_lines(column_only_lines),
    .data_in(data_in), .data_out(data_out));
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge row_strobe) if (select_a_n === 1'b1) rows_seen[shared_addr_lines] = 1'b1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // one request, held until taken, then timed to its response
  task automatic access(input logic wr, input logic [11:0] ad, input logic wd, output logic rd);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = ad;
    req_wdata = wd;
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    chk(req_ready, 1'b0, "ready while busy");
    n = 1;
    while (rsp_valid !== 1'b1 && n < 200) begin
      if (select_a_n === 1'b0) chk(row_strobe, 1'b1, "strobe low in column phase");
      if (!wr) chk(write_n, 1'b1, "write strobe in read");
      if (wr && write_n === 1'b0 && output_hold_ctl === 1'b1) chk(data_out, 1'b1, "output not high in write");
      if (wr && n > 35) chk(data_out, wd, "output after write");
      @(negedge clk);
      n++;
    end
    chk(n, wr ? WR_LAT : RD_LAT, "latency");
    chk(mem_u.row_q, ad[11:7], "row captured");
    rd = rsp_data;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(row_strobe, 1'b0, "strobe after reset");
    chk(select_a_n & select_b_n & write_n & output_hold_ctl, 1'b1, "idle pins");
    chk(req_ready, 1'b1, "ready after reset");
    $display("test reset done");
  endtask
  task automatic t_corners;
    logic r;
    foreach (tab_a[i]) access(1'b1, tab_a[i], ~i[0], r);
    foreach (tab_a[i]) begin
      access(1'b0, tab_a[i], 1'b0, r);
      chk(r, !i[0], "corner read");
    end
    $display("test corners done");
  endtask
  task automatic t_overwrite;
    logic r;
    foreach (tab_a[i]) begin
      access(1'b1, tab_a[i], i[0], r);
      chk(r, i[0], "write echo");
      access(1'b0, tab_a[i], 1'b0, r);
      chk(r, i[0], "reread");
    end
    $display("test overwrite done");
  endtask
  // idle past the refresh period, then data must survive
  task automatic t_refresh;
    logic r;
    rows_seen = '0;
    repeat (20000) @(negedge clk);
    chk(rows_seen, 32'hffffffff, "rows refreshed");
    foreach (tab_a[i]) begin
      access(1'b0, tab_a[i], 1'b0, r);
      chk(r, i[0], "data kept");
    end
    chk(mem_u.viol, 0, "memory timing");
    $display("test refresh done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 12'h000;
    req_wdata = 1'b0;
    fail_count = 0;
    n_tests = 0;
    rows_seen = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_reset;
    t_corners;
    t_overwrite;
    t_refresh;
    test_done;
  end
  initial begin
    #200000;
    fail_count++;
    test_done;
  end
endmodule
